// ==== hw/egs_pkg.sv ====
// constants, codes, default event table and carriers of the event sequencer
// assumes a single 250 MHz system clock shared by every user of the package
package egs_pkg;
   // clock and bus timing
   localparam int CLK_KHZ = 250000;
   localparam int I2C_KHZ = 100;
   localparam int I2C_QTR_CYC = CLK_KHZ / (4 * I2C_KHZ);
   localparam int MS_CYC = CLK_KHZ;
   localparam int SLP_A_MS = 1;
   localparam int SLP_B_MS = 10;
   localparam int SLP_C_MS = 100;
   localparam int I2C_BITS = 27;

   // event identifiers
   localparam logic [7:0] EVT_INIT = 8'h18;
   localparam logic [7:0] EVT_END = 8'hfe;
   localparam logic [7:0] EVT_MAX = 8'h7e;

   // command encodings
   localparam logic [3:0] CMD_LO_NIB = 4'hd;
   localparam logic [3:0] CMD_HI_NIB = 4'he;
   localparam logic [7:0] CMD_SLP_A = 8'hf0;
   localparam logic [7:0] CMD_SLP_B = 8'hf2;
   localparam logic [7:0] CMD_SLP_C = 8'hf4;

   // flash configuration layout
   localparam logic [7:0] CFG_MARK0 = 8'ha5;
   localparam logic [7:0] CFG_MARK1 = 8'h00;
   localparam logic [15:0] CFG_MARK_POS = 16'h0002;
   localparam logic [15:0] CFG_HDR_LEN = 16'h0014;
   localparam logic [1:0] CFG_NSTR = 2'h3;
   localparam logic [15:0] CFG_LANG_LEN = 16'h0002;

   // built-in table used when flash holds no events
   localparam int DEF_LEN = 45;
   localparam logic [7:0] DEF_TBL [0:DEF_LEN-1] = '{
      8'h14, 8'he0, 8'h16, 8'hd0, 8'h1a, 8'he2, 8'h1c, 8'hd2,
      8'h1e, 8'he4, 8'h20, 8'hd4,
      8'h00, 8'he6, 8'hd8, 8'hda, 8'h02, 8'he6, 8'he8, 8'hda,
      8'h04, 8'he6, 8'hd8, 8'hea, 8'h06, 8'he6, 8'he8, 8'hea,
      8'h08, 8'hd6, 8'hd8, 8'hda, 8'h0a, 8'hd6, 8'he8, 8'hda,
      8'h0c, 8'hd6, 8'hd8, 8'hea, 8'h0e, 8'hd6, 8'he8, 8'hea,
      8'hfe};

   // one three-byte bus write
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] regn;
      logic [7:0] val;
   } egs_i2c_s;
endpackage

// ==== hw/egs_cfg_mem.sv ====
// byte store for the event stream copied out of the flash configuration
// assumes one clock; read data appear one edge after the address
`timescale 1ns/10ps
module egs_cfg_mem #(
   parameter int DEPTH = 512,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic i_clk_sys,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [7:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [7:0] o_rdata
);
   logic [7:0] mem_q [0:DEPTH-1];

   // write port and registered read port
   always_ff @(posedge i_clk_sys) begin
      if (i_we) begin
         mem_q[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_q[i_raddr];
   end
endmodule

// ==== hw/egs_seq.sv ====
// event sequencer: loads the flash event stream, runs command lists on events
// assumes synchronous inputs on i_clk_sys and a pulled-up open-drain bus
//
// Summary of operation
// - rate selections raise even codes 0x00-0x0e
// - init event 0x18 runs once, first
// - byte 0xfe ends the event list
// - decode gpio low/high and 1/10/100 ms sleeps
// - odd byte starts three-byte bus write
// - no flash events: use built-in table
// - default: stream start/stop drive gpio 0
// - default: usb attach/detach drive gpio 1
// - default: dsd/pcm mode drive gpio 2
// - default: rate sets gpio 3, 4, 5
// - any flash event disables whole default table
// - section is event byte then commands
// - events follow language id after three strings
// - bus writes clocked at 100 kHz
// - config valid only with marker a5, 00
`timescale 1ns/10ps
module egs_seq #(
   parameter int MS_CYCLES = egs_pkg::MS_CYC,
   parameter int MEM_DEPTH = 512
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_cfg_valid,
   input wire logic [7:0] i_cfg_byte,
   input wire logic i_cfg_last,
   input wire logic i_evt_valid,
   input wire logic [7:0] i_evt_id,
   input wire logic i_rate_valid,
   input wire logic i_rate_fam44,
   input wire logic [1:0] i_rate_mult,
   output logic o_evt_ready,
   output logic o_busy,
   output logic o_cfg_present,
   output logic [7:0] o_gpio,
   input wire logic i_scl,
   output logic o_scl_o,
   output logic o_scl_oe,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   output logic o_i2c_nack
);
   localparam int AW = $clog2(MEM_DEPTH);

   // table index uses six address bits; sleeps must outlast the hold check
   if (MEM_DEPTH < 64 || MS_CYCLES < 8) begin : g_bad_params
      $error("egs_seq: MEM_DEPTH below 64 or MS_CYCLES below 8");
   end

   typedef enum {L_HDR, L_SLEN, L_SKIP, L_LANG, L_EVT, L_DONE} egs_ld_e;
   typedef enum {P_IDLE, P_RD, P_DEC, P_I2C, P_SLEEP} egs_ps_e;
   typedef enum {I_IDLE, I_START, I_BIT, I_STOP} egs_is_e;

   // event code of a selected sample rate
   function automatic logic [7:0] rate_code(input logic fam44, input logic [1:0] mult);
      rate_code = {4'h0, fam44, mult, 1'b0};
   endfunction

   // one-byte pin command
   function automatic logic is_gpio(input logic [7:0] b);
      is_gpio = !b[0] && (b[7:4] == egs_pkg::CMD_LO_NIB || b[7:4] == egs_pkg::CMD_HI_NIB);
   endfunction

   // section header or end of list
   function automatic logic is_sec(input logic [7:0] b);
      is_sec = (b == egs_pkg::EVT_END) || (!b[0] && b <= egs_pkg::EVT_MAX);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // loader of the flash configuration stream
   egs_ld_e ld_q;
   logic [15:0] cnt_q;
   logic [7:0] skip_q;
   logic [1:0] str_q;
   logic mark_ok_q;
   logic first_end_q;
   logic [AW:0] wr_cnt_q;
   logic use_flash_q;
   logic mem_we;

   assign mem_we = i_cfg_valid && ld_q == L_EVT && wr_cnt_q < (AW+1)'(MEM_DEPTH);

   // walk header, three strings and language id, then store events
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ld_q <= L_HDR;
         cnt_q <= 16'h0000;
         skip_q <= 8'h00;
         str_q <= 2'h0;
         mark_ok_q <= 1'b1;
         first_end_q <= 1'b1;
         wr_cnt_q <= '0;
         use_flash_q <= 1'b0;
      end else if (i_cfg_valid && ld_q != L_DONE) begin
         cnt_q <= cnt_q + 16'h0001;
         case (ld_q)
            L_HDR: begin
               if ((cnt_q == egs_pkg::CFG_MARK_POS && i_cfg_byte != egs_pkg::CFG_MARK0) ||
                   (cnt_q == egs_pkg::CFG_MARK_POS + 16'h0001 &&
                    i_cfg_byte != egs_pkg::CFG_MARK1)) begin
                  mark_ok_q <= 1'b0;
               end
               if (cnt_q == egs_pkg::CFG_HDR_LEN - 16'h0001) begin
                  ld_q <= L_SLEN;
               end
            end
            L_SLEN: begin
               skip_q <= i_cfg_byte;
               cnt_q <= 16'h0000;
               if (i_cfg_byte != 8'h00) begin
                  ld_q <= L_SKIP;
               end else begin
                  str_q <= str_q + 2'h1;
                  ld_q <= (str_q == egs_pkg::CFG_NSTR - 2'h1) ? L_LANG : L_SLEN;
               end
            end
            L_SKIP: begin
               skip_q <= skip_q - 8'h01;
               cnt_q <= 16'h0000;
               if (skip_q == 8'h01) begin
                  str_q <= str_q + 2'h1;
                  ld_q <= (str_q == egs_pkg::CFG_NSTR - 2'h1) ? L_LANG : L_SLEN;
               end
            end
            L_LANG: begin
               if (cnt_q == egs_pkg::CFG_LANG_LEN - 16'h0001) begin
                  ld_q <= L_EVT;
               end
            end
            L_EVT: begin
               if (mem_we) begin
                  wr_cnt_q <= wr_cnt_q + (AW+1)'(1);
               end
               if (wr_cnt_q == '0) begin
                  first_end_q <= (i_cfg_byte == egs_pkg::EVT_END);
               end
            end
            default: ld_q <= L_DONE;
         endcase
         if (i_cfg_last) begin
            ld_q <= L_DONE;
            // with a valid marker, any stored event switches the built-in table off
            use_flash_q <= mark_ok_q && ld_q == L_EVT &&
                           !(wr_cnt_q == '0 && i_cfg_byte == egs_pkg::EVT_END) &&
                           !(wr_cnt_q != '0 && first_end_q);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // byte source: stored stream or built-in table
   egs_ps_e ps_q;
   logic [AW-1:0] addr_q;
   logic [7:0] mem_rd;
   logic [7:0] rom_q;
   logic beyond_q;
   logic [7:0] byte_w;

   egs_cfg_mem #(.DEPTH(MEM_DEPTH), .AW(AW)) u_mem (
      .i_clk_sys(i_clk_sys),
      .i_we(mem_we),
      .i_waddr(wr_cnt_q[AW-1:0]),
      .i_wdata(i_cfg_byte),
      .i_raddr(addr_q),
      .o_rdata(mem_rd)
   );

   // registered table read and overrun guard, same latency as the store
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rom_q <= egs_pkg::EVT_END;
         beyond_q <= 1'b0;
      end else begin
         rom_q <= (addr_q < AW'(egs_pkg::DEF_LEN)) ? egs_pkg::DEF_TBL[addr_q[5:0]] :
                  egs_pkg::EVT_END;
         beyond_q <= use_flash_q && {1'b0, addr_q} >= wr_cnt_q;
      end
   end

   assign byte_w = beyond_q ? egs_pkg::EVT_END : (use_flash_q ? mem_rd : rom_q);

   ////////////////////////////////////////////////////////////////////////////
   // section walker and command decoder
   logic [7:0] evt_q;
   logic found_q;
   logic [1:0] argn_q;
   logic [6:0] arg_addr_q;
   logic [7:0] arg_reg_q;
   logic init_done_q;
   logic dec_cmd;
   logic i2c_go;
   logic slp_go;
   logic slp_done;
   logic i2c_busy;
   egs_pkg::egs_i2c_s i2c_cmd;

   assign dec_cmd = ps_q == P_DEC && found_q && argn_q == 2'h0;
   assign i2c_go = ps_q == P_DEC && found_q && argn_q == 2'h2;
   assign i2c_cmd = '{addr: arg_addr_q, regn: arg_reg_q, val: byte_w};
   assign slp_go = dec_cmd && (byte_w == egs_pkg::CMD_SLP_A || byte_w == egs_pkg::CMD_SLP_B ||
                               byte_w == egs_pkg::CMD_SLP_C);
   assign o_evt_ready = init_done_q && ps_q == P_IDLE;
   assign o_busy = ps_q != P_IDLE;

   // take events, scan sections, run commands in stored order
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ps_q <= P_IDLE;
         addr_q <= '0;
         evt_q <= 8'h00;
         found_q <= 1'b0;
         argn_q <= 2'h0;
         arg_addr_q <= 7'h00;
         arg_reg_q <= 8'h00;
         init_done_q <= 1'b0;
      end else begin
         case (ps_q)
            P_IDLE: begin
               addr_q <= '0;
               found_q <= 1'b0;
               argn_q <= 2'h0;
               if (!init_done_q && ld_q == L_DONE) begin
                  evt_q <= egs_pkg::EVT_INIT;
                  init_done_q <= 1'b1;
                  ps_q <= P_RD;
               end else if (init_done_q && i_rate_valid) begin
                  evt_q <= rate_code(i_rate_fam44, i_rate_mult);
                  ps_q <= P_RD;
               end else if (init_done_q && i_evt_valid) begin
                  evt_q <= i_evt_id;
                  ps_q <= P_RD;
               end
            end
            P_RD: ps_q <= P_DEC;
            P_DEC: begin
               addr_q <= addr_q + AW'(1);
               ps_q <= P_RD;
               if (argn_q != 2'h0) begin
                  // bus write operands are consumed even while skipping
                  if (argn_q == 2'h1) begin
                     arg_reg_q <= byte_w;
                  end
                  argn_q <= (argn_q == 2'h2) ? 2'h0 : argn_q + 2'h1;
                  if (i2c_go) begin
                     ps_q <= P_I2C;
                  end
               end else if (is_sec(byte_w)) begin
                  // end of list or of the matched section
                  if (found_q || byte_w == egs_pkg::EVT_END) begin
                     ps_q <= P_IDLE;
                  end
                  found_q <= byte_w == evt_q;
               end else if (byte_w[0]) begin
                  arg_addr_q <= byte_w[7:1];
                  argn_q <= 2'h1;
               end else if (slp_go) begin
                  ps_q <= P_SLEEP;
               end
            end
            P_I2C: begin
               if (!i2c_busy) begin
                  ps_q <= P_RD;
               end
            end
            P_SLEEP: begin
               if (slp_done) begin
                  ps_q <= P_RD;
               end
            end
            default: ps_q <= P_IDLE;
         endcase
      end
   end

   // pin commands
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_gpio <= 8'h00;
      end else if (dec_cmd && is_gpio(byte_w)) begin
         o_gpio[byte_w[3:1]] <= byte_w[7:4] == egs_pkg::CMD_HI_NIB;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep timer: millisecond enable divider and millisecond count
   logic [31:0] mdiv_q;
   logic [6:0] ms_q;

   assign slp_done = ps_q == P_SLEEP && ms_q == 7'h00;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         mdiv_q <= 32'h0000_0000;
         ms_q <= 7'h00;
      end else if (slp_go) begin
         mdiv_q <= 32'h0000_0000;
         ms_q <= (byte_w == egs_pkg::CMD_SLP_A) ? 7'(egs_pkg::SLP_A_MS) :
                 (byte_w == egs_pkg::CMD_SLP_B) ? 7'(egs_pkg::SLP_B_MS) :
                 7'(egs_pkg::SLP_C_MS);
      end else if (ms_q != 7'h00) begin
         if (mdiv_q == 32'(MS_CYCLES - 1)) begin
            mdiv_q <= 32'h0000_0000;
            ms_q <= ms_q - 7'h01;
         end else begin
            mdiv_q <= mdiv_q + 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus write engine: quarter-bit enable, start, 27 bits, stop
   egs_is_e is_q;
   logic [9:0] qdiv_q;
   logic qtick;
   logic [1:0] ph_q;
   logic [4:0] bit_q;
   logic [3:0] nine_q;
   logic [26:0] sh_q;

   assign i2c_busy = is_q != I_IDLE;
   assign qtick = qdiv_q == 10'(egs_pkg::I2C_QTR_CYC - 1);
   assign o_scl_o = 1'b0;
   assign o_sda_o = 1'b0;

   // quarter-bit divider, runs only during a transfer
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !i2c_busy || qtick) begin
         qdiv_q <= 10'h000;
      end else begin
         qdiv_q <= qdiv_q + 10'h001;
      end
   end

   // line sequencing; acknowledge slots release data
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         is_q <= I_IDLE;
         ph_q <= 2'h0;
         bit_q <= 5'h00;
         nine_q <= 4'h0;
         sh_q <= '0;
         o_scl_oe <= 1'b0;
         o_sda_oe <= 1'b0;
         o_i2c_nack <= 1'b0;
      end else if (i2c_go) begin
         is_q <= I_START;
         ph_q <= 2'h0;
         bit_q <= 5'h00;
         nine_q <= 4'h0;
         o_i2c_nack <= 1'b0;
         sh_q <= {i2c_cmd.addr, 1'b0, 1'b1, i2c_cmd.regn, 1'b1, i2c_cmd.val, 1'b1};
      end else if (qtick && !(is_q == I_BIT && ph_q == 2'h2 && !i_scl)) begin
         ph_q <= ph_q + 2'h1;
         case (is_q)
            I_START: begin
               if (ph_q == 2'h0) begin
                  o_sda_oe <= 1'b1;
               end else begin
                  o_scl_oe <= 1'b1;
                  ph_q <= 2'h0;
                  is_q <= I_BIT;
               end
            end
            I_BIT: begin
               if (ph_q == 2'h0) begin
                  o_sda_oe <= !sh_q[26];
               end else if (ph_q == 2'h1) begin
                  o_scl_oe <= 1'b0;
               end else if (ph_q == 2'h2) begin
                  if (nine_q == 4'h8 && i_sda) begin
                     o_i2c_nack <= 1'b1;
                  end
               end else begin
                  o_scl_oe <= 1'b1;
                  sh_q <= {sh_q[25:0], 1'b1};
                  nine_q <= (nine_q == 4'h8) ? 4'h0 : nine_q + 4'h1;
                  bit_q <= bit_q + 5'h01;
                  if (bit_q == 5'(egs_pkg::I2C_BITS - 1)) begin
                     is_q <= I_STOP;
                  end
               end
            end
            I_STOP: begin
               if (ph_q == 2'h0) begin
                  o_sda_oe <= 1'b1;
               end else if (ph_q == 2'h1) begin
                  o_scl_oe <= 1'b0;
               end else if (ph_q == 2'h2) begin
                  o_sda_oe <= 1'b0;
               end else begin
                  is_q <= I_IDLE;
               end
            end
            default: is_q <= I_IDLE;
         endcase
      end
   end

   assign o_cfg_present = use_flash_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_dec_end;
      ps_q == P_DEC && argn_q == 2'h0 && byte_w == egs_pkg::EVT_END;
   endsequence
   sequence s_write_issued;
      i2c_go ##1 is_q == I_START;
   endsequence

   a_rate_code: assert property (o_evt_ready && i_rate_valid |=>
      evt_q == {4'h0, $past(i_rate_fam44), $past(i_rate_mult), 1'b0})
      else $error("rate event code wrong");
   a_init_first: assert property ($rose(init_done_q) |-> evt_q == egs_pkg::EVT_INIT)
      else $error("first event is not init");
   a_end_stops: assert property (s_dec_end |=> ps_q == P_IDLE)
      else $error("end byte did not stop the walk");
   a_gpio_high: assert property (dec_cmd && byte_w[7:4] == egs_pkg::CMD_HI_NIB
      && !byte_w[0] |=> o_gpio[$past(byte_w[3:1])]) else $error("gpio high not set");
   a_gpio_hold: assert property (!dec_cmd |=> $stable(o_gpio))
      else $error("gpio moved without a command");
   a_write_addr: assert property (s_write_issued |-> sh_q[26:20] == $past(arg_addr_q))
      else $error("bus write address wrong");
   a_write_blocks: assert property (ps_q == P_I2C && i2c_busy |=> ps_q == P_I2C)
      else $error("next command started during write");
   a_sleep_holds: assert property (slp_go |=> ps_q == P_SLEEP [*8])
      else $error("sleep ended early");
   a_quarter_rate: assert property ($fell(o_scl_oe) |-> $past(qtick))
      else $error("bus clock off the quarter enable");
   a_default_off: assert property (use_flash_q |-> mark_ok_q)
      else $error("flash events used without marker");
endmodule

// ==== test/egs_i2c_tgt.sv ====
// bus target model for the sequencer's write traffic
// assumes wire levels sampled on the system clock and a pulled-up bus
`timescale 1ns/10ps
module egs_i2c_tgt (
   input wire logic i_clk_sys,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_oe = 1'b0,
   output logic o_byte_vld = 1'b0,
   output logic [7:0] o_byte = 8'h00,
   output int o_period = 0
);
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic act_q = 1'b0;
   int cnt_q = 0;
   int tick_q = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // start/stop detect, msb-first shift, ack in the ninth slot
   always @(posedge i_clk_sys) begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      o_byte_vld <= 1'b0;
      tick_q <= tick_q + 1;
      if (i_scl && scl_q && sda_q && !i_sda) begin
         act_q <= 1'b1;
         cnt_q <= 0;
      end else if (i_scl && scl_q && !sda_q && i_sda) begin
         act_q <= 1'b0;
      end else if (act_q && i_scl && !scl_q) begin
         o_period <= tick_q;
         tick_q <= 1;
         if (cnt_q < 8) begin
            o_byte <= {o_byte[6:0], i_sda};
            o_byte_vld <= (cnt_q == 7);
            cnt_q <= cnt_q + 1;
         end else begin
            cnt_q <= 0;
         end
      end else if (!i_scl && scl_q) begin
         o_sda_oe <= act_q && (cnt_q == 8);
      end
   end
endmodule

// ==== test/tb_top.sv ====
// self-checking bench of the event sequencer with a bus target model
// assumes egs_pkg compiled first; short millisecond count for speed
`timescale 1ns/10ps
module tb_top;
   localparam int MS = 10;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic cfg_vld = 1'b0;
   logic [7:0] cfg_byte = 8'h00;
   logic cfg_last = 1'b0;
   logic evt_vld = 1'b0;
   logic [7:0] evt_id = 8'h00;
   logic rate_vld = 1'b0;
   logic fam44 = 1'b0;
   logic [1:0] mult = 2'h0;
   logic evt_ready, busy, cfg_present, scl_oe, sda_oe, scl_o, sda_o, nack;
   logic tgt_oe, byte_vld;
   logic [7:0] gpio;
   logic [7:0] rx_byte;
   int period;
   // pulled-up open-drain wires: driven level only while enabled
   wire scl = scl_oe ? scl_o : 1'b1;
   wire sda = (sda_oe ? sda_o : 1'b1) & !tgt_oe;
   int errors = 0;
   int checked = 0;
   int cyc = 0;
   int t_prev = 0;
   int t_last = 0;
   int gap = 0;
   int r;
   logic [7:0] gq[$];
   logic [7:0] iq[$];
   logic [7:0] cb[$];
   logic [7:0] mdl = 8'h00;
   logic [7:0] prev = 8'h00;

   egs_seq #(.MS_CYCLES(MS), .MEM_DEPTH(512)) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_cfg_valid(cfg_vld), .i_cfg_byte(cfg_byte), .i_cfg_last(cfg_last),
      .i_evt_valid(evt_vld), .i_evt_id(evt_id), .i_rate_valid(rate_vld),
      .i_rate_fam44(fam44), .i_rate_mult(mult), .o_evt_ready(evt_ready), .o_busy(busy),
      .o_cfg_present(cfg_present), .o_gpio(gpio), .i_scl(scl), .o_scl_o(scl_o),
      .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .o_i2c_nack(nack));
   egs_i2c_tgt tgt (.i_clk_sys(i_clk_sys), .i_scl(scl), .i_sda(sda), .o_sda_oe(tgt_oe),
      .o_byte_vld(byte_vld), .o_byte(rx_byte), .o_period(period));

   // 250 mhz system clock
   always #2 i_clk_sys = ~i_clk_sys;

   ////////////////////////////////////////////////////////////////////////////////
   // compare tasks and verdict
   task automatic chk_gpio(string nm, logic [7:0] e, logic [7:0] g);
      checked++;
      if (e !== g) begin
         errors++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
      checked++;
      if (e !== g) begin
         errors++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_flag(string nm, logic e, logic g);
      checked++;
      if (e !== g) begin
         errors++;
         $display("mismatch %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // stimulus helpers
   task automatic set_bit(int n, logic v);
      if (mdl[n] !== v) begin
         mdl[n] = v;
         gq.push_back(mdl);
      end
   endtask
   task automatic do_reset();
      @(negedge i_clk_sys);
      i_rst = 1'b1;
      repeat (5) @(negedge i_clk_sys);
      i_rst = 1'b0;
      mdl = 8'h00;
   endtask
   // header, three two-byte strings and language id, then events
   task automatic build_hdr(logic [7:0] mk1);
      cb = {8'h00, 8'h00, 8'ha5, mk1};
      repeat (16) cb.push_back(8'h00);
      repeat (3) cb = {cb, 8'h02, 8'h41, 8'h00};
      cb = {cb, 8'h09, 8'h04};
   endtask
   task automatic send_cfg();
      if (cb.size() > 2) begin
         cb[0] = 8'(cb.size() - 2);
         cb[1] = 8'((cb.size() - 2) >> 8);
      end
      foreach (cb[k]) begin
         @(negedge i_clk_sys);
         cfg_vld = 1'b1;
         cfg_byte = cb[k];
         cfg_last = (k == cb.size() - 1);
      end
      @(negedge i_clk_sys);
      cfg_vld = 1'b0;
      cfg_last = 1'b0;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (evt_ready !== 1'b1 && n < 100000) begin
         @(negedge i_clk_sys);
         n++;
      end
      chk_flag("evt_ready", 1'b1, evt_ready);
      chk_flag("busy_idle", 1'b0, busy);
   endtask
   // rate codes carry family in bit 3 and multiplier in bits 2:1
   task automatic send_evt(logic [7:0] id, logic rt);
      @(negedge i_clk_sys);
      wait_ready();
      rate_vld = rt;
      evt_vld = !rt;
      evt_id = id;
      fam44 = id[3];
      mult = id[2:1];
      @(negedge i_clk_sys);
      rate_vld = 1'b0;
      evt_vld = 1'b0;
      @(negedge i_clk_sys);
      wait_ready();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // result watcher: every gpio change and received byte pops one note
   always @(negedge i_clk_sys) begin
      cyc++;
      if (i_rst) begin
         prev = gpio;
      end else if (gpio !== prev) begin
         prev = gpio;
         t_prev = t_last;
         t_last = cyc;
         chk_flag("bus_done_first", 1'b1, iq.size() == 0);
         chk_flag("gpio_noted", 1'b1, gq.size() != 0);
         if (gq.size() != 0) chk_gpio("gpio", gq.pop_front(), gpio);
      end
      if (byte_vld === 1'b1) begin
         chk_flag("byte_noted", 1'b1, iq.size() != 0);
         if (iq.size() != 0) chk_byte("bus_byte", iq.pop_front(), rx_byte);
         chk_flag("scl_period", 1'b1, period == egs_pkg::CLK_KHZ / 100);
         chk_flag("busy_in_write", 1'b1, busy);
      end
   end

   // watchdog: the bus write dominates, well under this span
   initial begin
      #(4 * 100000);
      errors++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(24));
      repeat (5) @(negedge i_clk_sys);
      i_rst = 1'b0;
      // no flash configuration: built-in table
      cb = {8'hff};
      send_cfg();
      chk_flag("cfg_present", 1'b0, cfg_present);
      for (int k = 0; k < 6; k++) begin
         set_bit(k / 2, (k % 2) == 0);
         send_evt(8'h14 + 8'(2 * k) + ((k > 1) ? 8'h02 : 8'h00), 1'b0);
      end
      send_evt(8'h22, 1'b0);
      r = $urandom_range(7, 0);
      for (int k = 0; k < 8; k++) begin
         evt_id = 8'(((k + r) % 8) * 2);
         set_bit(3, !evt_id[3]);
         set_bit(4, evt_id[1]);
         set_bit(5, evt_id[2]);
         send_evt(evt_id, 1'b1);
      end
      // flash events: init, sleeps, bus write, list end
      do_reset();
      build_hdr(8'h00);
      cb.push_back(8'h18);
      for (int n = 0; n < 8; n++) cb.push_back(8'he0 + 8'(2 * n));
      for (int n = 0; n < 8; n++) cb.push_back(8'hd0 + 8'(2 * n));
      cb = {cb, 8'h14, 8'he2, 8'hf0, 8'hd2, 8'hf2, 8'he2, 8'hf4, 8'hd2};
      cb = {cb, 8'h00, 8'h21, 8'h56, 8'h5a, 8'hee, 8'hfe, 8'h16, 8'he6};
      for (int n = 0; n < 8; n++) set_bit(n, 1'b1);
      for (int n = 0; n < 8; n++) set_bit(n, 1'b0);
      send_cfg();
      chk_flag("cfg_present", 1'b1, cfg_present);
      set_bit(1, 1'b1);
      set_bit(1, 1'b0);
      set_bit(1, 1'b1);
      set_bit(1, 1'b0);
      send_evt(8'h14, 1'b0);
      gap = t_last - t_prev;
      chk_flag("sleep_gap", 1'b1, gap >= 100 * MS && gap <= 100 * MS + 40);
      // section stored after the list end must not run
      send_evt(8'h16, 1'b0);
      // built-in table would raise gpio 1 here
      send_evt(8'h1a, 1'b0);
      iq = {8'h20, 8'h56, 8'h5a};
      set_bit(7, 1'b1);
      send_evt(8'h00, 1'b1);
      chk_flag("nack", 1'b0, nack);
      // bad marker: configuration ignored, built-in table again
      do_reset();
      build_hdr(8'h01);
      cb = {cb, 8'h14, 8'he4, 8'hfe};
      send_cfg();
      chk_flag("cfg_present", 1'b0, cfg_present);
      set_bit(0, 1'b1);
      send_evt(8'h14, 1'b0);
      chk_flag("notes_drained", 1'b1, gq.size() == 0 && iq.size() == 0);
      finish_test();
   end
endmodule
